// ===== ssf_sync_channel_framer.sv
// Sync channel framer: turns line items into sync words and lane words, one per link slot.
// Assumes items come from logic on clock; link_clock is a pin sampled here.
`timescale 1ns/1ns

module ssf_sync_channel_framer (
    input  wire logic                       clock,         // Pixel output clock
    input  wire logic                       reset,         // Synchronous, active high
    input  wire logic                       link_clock,    // Link word clock pin
    input  wire logic                       mode_8bit,     // High selects eight-bit words
    input  wire logic                       crc_seed_ones, // High seeds CRC with ones
    input  wire logic                       reg_wr_en,     // Register write strobe
    input  wire logic                       reg_rd_en,     // Register read strobe
    input  wire logic [7:0]                 reg_addr,      // Register offset
    input  wire logic [9:0]                 reg_wr_data,   // Write data
    output logic      [9:0]                 reg_rd_data,   // Read data, next cycle
    input  wire logic                       item_valid,    // Item offered
    output logic                            item_ready,    // Buffer has room
    input  wire logic [1:0]                 item_kind,     // Begin, finish, black, image
    input  wire logic                       item_edge,     // First or last line of frame
    input  wire logic [7:0]                 item_window,   // Active window mask
    input  wire logic [39:0]                item_lanes,    // Four ten-bit pixels
    output logic      [9:0]                 sync_word,     // Sync channel word
    output logic      [39:0]                lane_words,    // Four lane words
    output logic                            word_strobe    // One cycle per new word
);

    // ************************************************************
    // Link clock sampling
    // ************************************************************
    logic link_s1_ff;
    logic link_s2_ff;
    logic link_s3_ff;
    logic link_lvl_ff;
    logic nxt_link_lvl;
    wire  slot;

    assign nxt_link_lvl = (link_s2_ff == link_s3_ff) ? link_s2_ff : link_lvl_ff;
    // A slot is a settled rise of the link clock
    assign slot = link_s2_ff & link_s3_ff & ~link_lvl_ff;

    always_ff @(posedge clock) begin
        if (reset) begin
            link_s1_ff  <= 1'h0;
            link_s2_ff  <= 1'h0;
            link_s3_ff  <= 1'h0;
            link_lvl_ff <= 1'h0;
        end else begin
            link_s1_ff  <= link_clock;
            link_s2_ff  <= link_s1_ff;
            link_s3_ff  <= link_s2_ff;
            link_lvl_ff <= nxt_link_lvl;
        end
    end

    // ************************************************************
    // Registers
    // ************************************************************
    logic [9:0] train_data_ff;
    logic [6:0] sync_id_ff;
    logic [9:0] black_ff;
    logic [9:0] image_ff;
    logic [9:0] crc_class_ff;
    logic [9:0] train_sync_ff;
    logic [9:0] rd_data_ff;
    logic [9:0] status;
    logic [9:0] nxt_rd_data;

    always_ff @(posedge clock) begin
        if (reset) begin
            train_data_ff <= ssf_pkg::RST_TRAIN_DATA; // [R12]
            sync_id_ff    <= ssf_pkg::RST_SYNC_ID;    // [R23]
            black_ff      <= ssf_pkg::RST_BLACK;      // [R4]
            image_ff      <= ssf_pkg::RST_IMAGE;      // [R4]
            crc_class_ff  <= ssf_pkg::RST_CRC;        // [R5]
            train_sync_ff <= ssf_pkg::RST_TRAIN_SYNC; // [R5]
        end else if (reg_wr_en) begin
            if (reg_addr == ssf_pkg::REG_TRAIN_DATA) train_data_ff <= reg_wr_data;
            if (reg_addr == ssf_pkg::REG_SYNC_ID)    sync_id_ff    <= reg_wr_data[6:0];
            if (reg_addr == ssf_pkg::REG_BLACK)      black_ff      <= reg_wr_data;
            if (reg_addr == ssf_pkg::REG_IMAGE)      image_ff      <= reg_wr_data;
            if (reg_addr == ssf_pkg::REG_CRC)        crc_class_ff  <= reg_wr_data;
            if (reg_addr == ssf_pkg::REG_TRAIN_SYNC) train_sync_ff <= reg_wr_data;
        end
    end

    // Unmapped offsets read as zero
    assign nxt_rd_data = (reg_addr == ssf_pkg::REG_TRAIN_DATA) ? train_data_ff :
                         (reg_addr == ssf_pkg::REG_SYNC_ID)    ? {3'h0, sync_id_ff} :
                         (reg_addr == ssf_pkg::REG_BLACK)      ? black_ff :
                         (reg_addr == ssf_pkg::REG_IMAGE)      ? image_ff :
                         (reg_addr == ssf_pkg::REG_CRC)        ? crc_class_ff :
                         (reg_addr == ssf_pkg::REG_TRAIN_SYNC) ? train_sync_ff :
                         (reg_addr == ssf_pkg::REG_STATUS)     ? status : 10'h000;

    always_ff @(posedge clock) begin
        if (reset) rd_data_ff <= 10'h000;
        else if (reg_rd_en) rd_data_ff <= nxt_rd_data;
    end

    // ************************************************************
    // Two-entry item buffer
    // ************************************************************
    logic [50:0] buf_ff [2];
    logic        wr_ptr_ff;
    logic        rd_ptr_ff;
    logic [1:0]  count_ff;
    logic        ready_ff;
    logic [1:0]  nxt_count;
    wire         push;
    wire         pop;
    wire         have_item;
    wire  [50:0] head;
    wire  [1:0]  head_kind;
    wire         head_edge;
    wire  [7:0]  head_window;
    wire  [39:0] head_lanes;
    ssf_pkg::ssf_phase_t phase_ff;
    ssf_pkg::ssf_phase_t nxt_phase;

    assign push        = item_valid & ready_ff;
    assign have_item   = (count_ff != 2'h0);
    assign pop         = slot & (phase_ff == ssf_pkg::PH_ITEM) & have_item;
    assign nxt_count   = count_ff + {1'h0, push} - {1'h0, pop};
    assign head        = buf_ff[rd_ptr_ff];
    assign head_kind   = head[ssf_pkg::ITEM_KIND_LSB +: 2];
    assign head_edge   = head[ssf_pkg::ITEM_EDGE_BIT];
    assign head_window = head[ssf_pkg::ITEM_WIN_LSB +: ssf_pkg::WIN_W];
    assign head_lanes  = head[ssf_pkg::LANE_BUS_W-1:0];

    always_ff @(posedge clock) begin
        if (reset) begin
            wr_ptr_ff <= 1'h0;
            rd_ptr_ff <= 1'h0;
            count_ff  <= 2'h0;
            ready_ff  <= 1'h0;
        end else begin
            if (push) wr_ptr_ff <= ~wr_ptr_ff;
            if (pop)  rd_ptr_ff <= ~rd_ptr_ff;
            count_ff <= nxt_count;
            // Ready drops as soon as both entries fill, so a slow link stalls the source
            ready_ff <= (nxt_count != 2'h2);
        end
    end

    always_ff @(posedge clock) begin
        if (push) buf_ff[wr_ptr_ff] <= {item_kind, item_edge, item_window, item_lanes};
    end

    // ************************************************************
    // Highest active window
    // ************************************************************
    wire [2:0] wid_chain [9];

    assign wid_chain[0] = 3'h0;
    generate
        for (genvar w = 0; w < ssf_pkg::WIN_W; w++) begin : g_wid
            // Later bits override earlier ones, so the top set bit wins
            assign wid_chain[w+1] = head_window[w] ? 3'(w) : wid_chain[w]; // [R2]
        end
    endgenerate

    // ************************************************************
    // Word formatting
    // ************************************************************
    function automatic logic [9:0] fmt(input logic [9:0] f, input logic m8);
        // Eight-bit words drop the two low field bits and sit in the low byte
        fmt = m8 ? {2'h0, f[9:2]} : f; // [R10] [R13] [R25]
    endfunction

    function automatic logic [9:0] crc_step(input logic [9:0] c, input logic [9:0] d, input logic m8);
        logic [9:0] r;
        logic       fb;
        r = c;
        if (m8) begin
            for (int b = 7; b >= 0; b--) begin
                fb = r[7] ^ d[b];
                r  = {2'h0, r[6:0], 1'h0};
                if (fb) r[7:0] = r[7:0] ^ ssf_pkg::CRC8_POLY; // [R19]
            end
        end else begin
            for (int b = 9; b >= 0; b--) begin
                fb = r[9] ^ d[b];
                r  = {r[8:0], 1'h0};
                if (fb) r = r ^ ssf_pkg::CRC10_POLY; // [R16]
            end
        end
        crc_step = r;
    endfunction

    logic [2:0]  wid_ff;
    logic [2:0]  nxt_wid;
    logic [9:0]  sync_ff;
    logic [9:0]  nxt_sync;
    logic [39:0] lanes_ff;
    logic [39:0] nxt_lanes;
    logic        strobe_ff;
    wire  [9:0]  sync_id_word;
    wire  [9:0]  wid_word;
    wire  [2:0]  begin_code;
    wire  [2:0]  finish_code;
    wire  [39:0] train_lanes;
    wire  [39:0] data_lanes;
    wire  [39:0] crc_lanes;
    wire         crc_reload;
    wire         crc_update;
    wire         is_data;

    assign begin_code  = head_edge ? ssf_pkg::CODE_FRAME_BEGIN : ssf_pkg::CODE_LINE_BEGIN;     // [R24]
    assign finish_code = head_edge ? ssf_pkg::CODE_FRAME_FINISH : ssf_pkg::CODE_LINE_FINISH;   // [R24]
    // Identifier part of a sync word; eight-bit mode keeps bits 6:2
    assign sync_id_word = mode_8bit ? {5'h00, sync_id_ff[6:2]} : {3'h0, sync_id_ff}; // [R7] [R8] [R23]
    assign wid_word     = mode_8bit ? {5'h00, wid_ff, 2'h0} : {7'h00, wid_ff};         // [R1] [R9]
    assign is_data      = (head_kind == ssf_pkg::KIND_BLACK) | (head_kind == ssf_pkg::KIND_IMAGE);
    assign crc_reload   = pop & (head_kind == ssf_pkg::KIND_BEGIN);  // [R17]
    // Only data items feed the CRC; sync slots and training leave it alone
    assign crc_update   = pop & is_data;                             // [R15] [R20]

    // ************************************************************
    // Per-lane CRC
    // ************************************************************
    logic [9:0] crc_ff [4];

    generate
        for (genvar i = 0; i < ssf_pkg::LANES; i++) begin : g_lane
            wire [9:0] pix_word;
            wire [9:0] nxt_crc;

            assign train_lanes[i*10 +: 10] = fmt(train_data_ff, mode_8bit); // [R11] [R12] [R13]
            assign pix_word                = fmt(head_lanes[i*10 +: 10], mode_8bit);
            assign data_lanes[i*10 +: 10]  = pix_word;
            // CRC word has the current mode width
            assign crc_lanes[i*10 +: 10]   = mode_8bit ? {2'h0, crc_ff[i][7:0]} : crc_ff[i]; // [R26] [R14]
            assign nxt_crc = crc_reload ? (crc_seed_ones ? 10'h3ff : 10'h000) :       // [R18]
                             crc_update ? crc_step(crc_ff[i], pix_word, mode_8bit) :  // [R17]
                             crc_ff[i];

            always_ff @(posedge clock) begin
                if (reset) crc_ff[i] <= 10'h000;
                else crc_ff[i] <= nxt_crc;
            end
        end
    endgenerate

    // ************************************************************
    // Slot sequencing
    // ************************************************************
    always_comb begin
        nxt_phase = phase_ff;
        nxt_sync  = sync_ff;
        nxt_lanes = lanes_ff;
        nxt_wid   = wid_ff;
        if (slot) begin
            nxt_sync  = fmt(train_sync_ff, mode_8bit); // [R11]
            nxt_lanes = train_lanes;
            case (phase_ff)
                ssf_pkg::PH_WID_BEGIN: begin
                    nxt_sync  = wid_word;            // [R1]
                    nxt_phase = ssf_pkg::PH_ITEM;
                end
                ssf_pkg::PH_WID_FINISH: begin
                    nxt_sync  = wid_word;            // [R1]
                    nxt_phase = ssf_pkg::PH_CRC;
                end
                ssf_pkg::PH_CRC: begin
                    nxt_sync  = fmt(crc_class_ff, mode_8bit); // [R6] [R5]
                    nxt_lanes = crc_lanes;                    // [R14] [R26]
                    nxt_phase = ssf_pkg::PH_ITEM;
                end
                ssf_pkg::PH_ITEM: begin
                    if (have_item) begin
                        case (head_kind)
                            ssf_pkg::KIND_BEGIN: begin
                                nxt_sync  = mode_8bit ? {2'h0, begin_code, sync_id_word[4:0]} : // [R8]
                                                        {begin_code, sync_id_word[6:0]};        // [R23]
                                nxt_wid   = wid_chain[8];
                                nxt_phase = ssf_pkg::PH_WID_BEGIN;
                            end
                            ssf_pkg::KIND_FINISH: begin
                                nxt_sync  = mode_8bit ? {2'h0, finish_code, sync_id_word[4:0]} : // [R8]
                                                        {finish_code, sync_id_word[6:0]};        // [R23]
                                nxt_wid   = wid_chain[8];
                                nxt_phase = ssf_pkg::PH_WID_FINISH;
                            end
                            ssf_pkg::KIND_BLACK: begin
                                nxt_sync  = fmt(black_ff, mode_8bit); // [R3] [R4]
                                nxt_lanes = data_lanes;
                            end
                            default: begin
                                nxt_sync  = fmt(image_ff, mode_8bit); // [R3] [R4]
                                nxt_lanes = data_lanes;
                            end
                        endcase
                    end
                end
                default: nxt_phase = ssf_pkg::PH_ITEM;
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            phase_ff  <= ssf_pkg::PH_ITEM;
            sync_ff   <= 10'h000;
            lanes_ff  <= 40'h0;
            wid_ff    <= 3'h0;
            strobe_ff <= 1'h0;
        end else begin
            phase_ff  <= nxt_phase;
            sync_ff   <= nxt_sync;
            lanes_ff  <= nxt_lanes;
            wid_ff    <= nxt_wid;
            strobe_ff <= slot;
        end
    end

    // ************************************************************
    // Line and kernel state
    // ************************************************************
    logic       in_line_ff;
    logic       frame_active_ff;
    logic       half_ff;
    logic [7:0] kernel_cnt_ff;

    always_ff @(posedge clock) begin
        if (reset) begin
            in_line_ff      <= 1'h0;
            frame_active_ff <= 1'h0;
            half_ff         <= 1'h0;
            kernel_cnt_ff   <= 8'h00;
        end else if (crc_reload) begin
            in_line_ff    <= 1'h1;
            half_ff       <= 1'h0;
            kernel_cnt_ff <= 8'h00;
            if (head_edge) frame_active_ff <= 1'h1;
        end else if (pop & (head_kind == ssf_pkg::KIND_FINISH)) begin
            in_line_ff <= 1'h0;
            if (head_edge) frame_active_ff <= 1'h0;
        end else if (crc_update) begin
            // Two data items carry one eight-pixel kernel over four lanes
            half_ff <= ~half_ff; // [R22]
            if (half_ff == ssf_pkg::KERNEL_LAST_HALF) kernel_cnt_ff <= kernel_cnt_ff + 8'h01; // [R22]
        end
    end

    assign status = {kernel_cnt_ff, in_line_ff, frame_active_ff};

    assign reg_rd_data = rd_data_ff;
    assign item_ready  = ready_ff;
    assign sync_word   = sync_ff;
    assign lane_words  = lanes_ff;
    assign word_strobe = strobe_ff;

    // ************************************************************
    // Checks
    // ************************************************************
    begin_sync_a: assert property (@(posedge clock) disable iff (reset) // [R23]
        (crc_reload && !mode_8bit) |=> sync_ff[9:7] == ($past(head_edge) ? 3'h5 : 3'h1))
        else $error("begin sync code wrong");

    wid_word_a: assert property (@(posedge clock) disable iff (reset) // [R1]
        (pop && head_kind == ssf_pkg::KIND_BEGIN && !mode_8bit) |=> strobe_ff ##[1:300]
        (strobe_ff && sync_ff == {7'h00, wid_ff}))
        else $error("window id word missing");

    wid_high_a: assert property (@(posedge clock) disable iff (reset) // [R2]
        (head_window != 8'h00) |-> ((head_window >> wid_chain[8]) == 8'h01))
        else $error("window id not highest");

    crc_slot_a: assert property (@(posedge clock) disable iff (reset) // [R6]
        (slot && phase_ff == ssf_pkg::PH_CRC && !mode_8bit) |=>
        (sync_ff == $past(crc_class_ff) && lanes_ff[9:0] == $past(crc_ff[0])))
        else $error("crc slot content wrong");

    train_idle_a: assert property (@(posedge clock) disable iff (reset) // [R11]
        (slot && phase_ff == ssf_pkg::PH_ITEM && !have_item && !mode_8bit) |=>
        (lanes_ff[39:30] == $past(train_data_ff) && sync_ff == $past(train_sync_ff)))
        else $error("idle training wrong");

    crc_seed_a: assert property (@(posedge clock) disable iff (reset) // [R18]
        crc_reload |=> crc_ff[1] == ($past(crc_seed_ones) ? 10'h3ff : 10'h000))
        else $error("crc seed wrong");

    crc_hold_a: assert property (@(posedge clock) disable iff (reset) // [R15]
        (!crc_reload && !crc_update) |=> $stable(crc_ff[2]))
        else $error("crc moved outside data");

    class8_a: assert property (@(posedge clock) disable iff (reset) // [R10]
        (pop && head_kind == ssf_pkg::KIND_IMAGE && mode_8bit) |=> sync_ff == {2'h0, $past(image_ff[9:2])})
        else $error("eight-bit class code wrong");

    buf_full_a: assert property (@(posedge clock) disable iff (reset)
        (count_ff == 2'h2) |-> !ready_ff)
        else $error("ready while full");

endmodule

// ===== ssf_pkg.sv
// Constants, register map and encodings for the sync channel framer.
// Assumes one pixel output clock domain; the link clock is sampled, not used as a clock.
// What this block does
// [R1] After each sync word send a word carrying the 3-bit window id, 0 to 7.
// [R2] With several windows active, report only the largest window id.
// [R3] Every other sync slot carries a black, image, CRC or training class code.
// [R4] Black and image class codes come from fields defaulting 0x015 and 0x035.
// [R5] CRC and sync training class codes come from fields defaulting 0x059 and 0x3A6.
// [R6] While lanes send their CRC words the sync channel sends the CRC class code.
// [R7] Eight-bit sync words use the same fields minus their two low bits.
// [R8] Eight-bit sync: bits 7:5 frame/line begin/finish code, bits 4:0 identifier.
// [R9] Eight-bit window id word holds the id in bits 4:2, other bits zero.
// [R10] Eight-bit class codes are bits 9:2 of the ten-bit fields.
// [R11] When idle, all lanes send training pattern, sync sends training class code.
// [R12] Lane training pattern has its own field, default 0x3A6.
// [R13] Eight-bit lane training pattern is bits 9:2 of that field.
// [R14] Each lane sends its own CRC over its line data at the line's end.
// [R15] Idle and training words are left out of the CRC.
// [R16] Ten-bit CRC polynomial has terms at powers 10, 9, 6, 3, 2, 1, 0.
// [R17] CRC reloads with the seed at each line start, updates per data word.
// [R18] Seed select bit: zero seeds all zeros, one seeds all ones, both modes.
// [R19] Eight-bit CRC polynomial has terms at powers 8, 6, 3, 2, 0.
// [R20] CRC spans the whole line, covering all overlapping windows together.
// [R21] Receiver gets no error protection on sync words, only on lane words.
// [R22] Pixels go out in kernels eight wide, one tall, two pixels per lane.
// [R23] Ten-bit sync: bits 9:7 begin/finish code, bits 6:0 identifier default 0x2A.
// [R24] Lines open with line begin, close with line finish; frame codes at ends.
// [R25] Words are ten bits long in ten-bit mode and eight in eight-bit mode.
// [R26] Lane CRC word has the mode's width, sent in the CRC class code slot.
package ssf_pkg;

    localparam int LANES      = 4;
    localparam int WORD_W     = 10;
    localparam int LANE_BUS_W = 40;
    localparam int WIN_W      = 8;
    localparam int BUF_DEPTH  = 2;
    localparam int ITEM_W     = 51;

    // Item field positions
    localparam int ITEM_WIN_LSB  = 40;
    localparam int ITEM_EDGE_BIT = 48;
    localparam int ITEM_KIND_LSB = 49;

    // Item kinds
    localparam logic [1:0] KIND_BEGIN  = 2'h0;
    localparam logic [1:0] KIND_FINISH = 2'h1;
    localparam logic [1:0] KIND_BLACK  = 2'h2;
    localparam logic [1:0] KIND_IMAGE  = 2'h3;

    // Register offsets
    localparam logic [7:0] REG_TRAIN_DATA = 8'h82;
    localparam logic [7:0] REG_SYNC_ID    = 8'h83;
    localparam logic [7:0] REG_BLACK      = 8'h84;
    localparam logic [7:0] REG_IMAGE      = 8'h85;
    localparam logic [7:0] REG_CRC        = 8'h86;
    localparam logic [7:0] REG_TRAIN_SYNC = 8'h87;
    localparam logic [7:0] REG_STATUS     = 8'h88;

    // Reset values
    localparam logic [9:0] RST_TRAIN_DATA = 10'h3a6;
    localparam logic [6:0] RST_SYNC_ID    = 7'h2a;
    localparam logic [9:0] RST_BLACK      = 10'h015;
    localparam logic [9:0] RST_IMAGE      = 10'h035;
    localparam logic [9:0] RST_CRC        = 10'h059;
    localparam logic [9:0] RST_TRAIN_SYNC = 10'h3a6;

    // Sync word kind codes
    localparam logic [2:0] CODE_FRAME_BEGIN  = 3'h5;
    localparam logic [2:0] CODE_FRAME_FINISH = 3'h6;
    localparam logic [2:0] CODE_LINE_BEGIN   = 3'h1;
    localparam logic [2:0] CODE_LINE_FINISH  = 3'h2;

    // CRC generators without the top term
    localparam logic [9:0] CRC10_POLY = 10'h24f;
    localparam logic [7:0] CRC8_POLY  = 8'h4d;

    // Data items per eight-pixel kernel: two pixels on each of four lanes
    localparam logic KERNEL_LAST_HALF = 1'h1;

    typedef enum logic [1:0] {
        PH_ITEM,
        PH_WID_BEGIN,
        PH_WID_FINISH,
        PH_CRC
    } ssf_phase_t;

endpackage

// ===== ssf_link_rx.sv
// Receiver model for the framer's link: makes the link clock pin and logs each word pair.
// Assumes word_strobe marks exactly one new word pair per slot.
`timescale 1ns/1ns

module ssf_link_rx (
    input  wire logic        clock,       // Pixel clock
    input  wire logic        word_strobe, // New words present
    input  wire logic [9:0]  sync_word,   // Sync word
    input  wire logic [39:0] lane_words,  // Lane words
    output logic             link_clock   // Link word clock pin
);
    logic [49:0] got_q[$];

    // Free running at one eighth of clock; offset, but its edges keep a fixed phase to clock
    initial begin
        link_clock = 1'b0;
        #137;
        forever #400 link_clock = ~link_clock;
    end

    // Sync words are logged as sent; only lane words carry a CRC
    // Logged on the falling edge, where strobe and words have settled
    always @(negedge clock) if (word_strobe === 1'b1) got_q.push_back({sync_word, lane_words});
endmodule

// ===== ssf_sync_channel_framer_tb_top.sv
// Bench: one random line in each word mode through the framer, checked at the link.
// Assumes the receiver model logs every word pair it sees.
`timescale 1ns/1ns
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin error_cnt++; $display("[FAIL] %0t %h %h", $time, g, e); end end

module ssf_sync_channel_framer_tb_top;
    logic        clock, reset, link_clock, mode_8bit, crc_seed_ones, reg_wr_en, reg_rd_en;
    logic        item_valid, item_ready, item_edge, word_strobe;
    logic [1:0]  item_kind;
    logic [7:0]  reg_addr, item_window;
    logic [9:0]  reg_wr_data, reg_rd_data, sync_word, image_pixel_class;
    logic [39:0] item_lanes, lane_words;
    logic [49:0] trn, g, exp_q[$];
    logic [15:0] rnd = 16'h7a34;
    int          error_cnt, cmp_count;

    ssf_sync_channel_framer DUT (.clock, .reset, .link_clock, .mode_8bit, .crc_seed_ones, .reg_wr_en, .reg_rd_en,
        .reg_addr, .reg_wr_data, .reg_rd_data, .item_valid, .item_ready, .item_kind, .item_edge, .item_window,
        .item_lanes, .sync_word, .lane_words, .word_strobe);
    ssf_link_rx RX (.clock, .word_strobe, .sync_word, .lane_words, .link_clock);

    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end

    function automatic logic [15:0] lfsr(logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction
    function automatic logic [9:0] w(logic [9:0] v);
        return mode_8bit ? {2'h0, v[9:2]} : v;
    endfunction
    // Serial MSB first, no final inversion
    function automatic logic [9:0] crc_step(logic [9:0] c, logic [9:0] d);
        logic fb;
        for (int b = (mode_8bit ? 7 : 9); b >= 0; b--) begin
            fb = c[mode_8bit ? 7 : 9] ^ d[b];
            c = {c[8:0], 1'b0} & w(10'h3ff);
            if (fb) c = c ^ (mode_8bit ? 10'h04d : 10'h24f);
        end
        return c;
    endfunction

    task automatic tally_and_finish();
        $display("errors %0d compares %0d", error_cnt, cmp_count);
        if (error_cnt == 0 && cmp_count > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic rd(logic [7:0] a, logic [9:0] e);
        @(negedge clock);
        {reg_rd_en, reg_addr} = {1'b1, a};
        @(negedge clock);
        reg_rd_en = 1'b0;
        @(negedge clock);
        `CHK(reg_rd_data, e)
    endtask
    task automatic send(logic [1:0] k, logic [39:0] px);
        int n;
        @(negedge clock);
        {item_valid, item_kind, item_lanes} = {1'b1, k, px};
        // Ready is read on the falling edge, where it has settled
        for (n = 0; item_ready !== 1'b1 && n < 300; n++) @(negedge clock);
        @(negedge clock);
        item_valid = 1'b0;
        if (n >= 300) begin error_cnt++; tally_and_finish(); end
    endtask
    task automatic pop_word(output logic [49:0] q, input logic skip);
        for (int n = 0; n < 400; n++) begin
            @(negedge clock);
            if (RX.got_q.size() > 0) begin
                q = RX.got_q.pop_front();
                if (!skip || q !== trn) return;
            end
        end
        error_cnt++;
        tally_and_finish();
    endtask
    task automatic run_line();
        logic [39:0] px, crc, tl, tp;
        logic [9:0]  wd;
        tp = trn[39:0];
        rnd = lfsr(rnd);
        px = {4{rnd[9:0]}};
        item_window = mode_8bit ? 8'h81 : (rnd[7:0] | 8'h01);
        item_edge = ~mode_8bit;
        for (int i = 0; i < 8; i++) if (item_window[i]) wd = mode_8bit ? {5'h0, i[2:0], 2'h0} : {7'h0, i[2:0]};
        crc = {4{crc_seed_ones ? w(10'h3ff) : 10'h0}};
        exp_q.push_back({w({item_edge ? 3'h5 : 3'h1, 7'h2a}), tp});
        exp_q.push_back({wd, tp});
        send(ssf_pkg::KIND_BEGIN, px);
        for (int d = 0; d < 4; d++) begin
            rnd = lfsr(rnd);
            px = {rnd[9:0], rnd[15:6], ~rnd[9:0], rnd[13:4]};
            for (int i = 0; i < 4; i++) begin
                tl[10*i+:10] = w(px[10*i+:10]);
                crc[10*i+:10] = crc_step(crc[10*i+:10], tl[10*i+:10]);
            end
            exp_q.push_back({w(rnd[1] ? image_pixel_class : 10'h015), tl});
            send(rnd[1] ? ssf_pkg::KIND_IMAGE : ssf_pkg::KIND_BLACK, px);
        end
        exp_q.push_back({w({item_edge ? 3'h6 : 3'h2, 7'h2a}), tp});
        exp_q.push_back({wd, tp});
        exp_q.push_back({w(10'h059), crc});
        send(ssf_pkg::KIND_FINISH, px);
    endtask
    task automatic check_line();
        logic [49:0] q, e;
        for (int j = 0; j < 9; j++) begin
            pop_word(q, 1'b1);
            e = exp_q.pop_front();
            `CHK(q, e)
        end
    endtask

    initial begin
        {reset, mode_8bit, crc_seed_ones, reg_wr_en, reg_rd_en, item_valid, item_edge} = 7'h40;
        {item_kind, reg_addr, item_window, reg_wr_data, item_lanes} = '0;
        repeat (16) @(negedge clock);
        reset = 1'b0;
        rd(ssf_pkg::REG_TRAIN_DATA, 10'h3a6);
        rd(ssf_pkg::REG_BLACK, 10'h015);
        rd(ssf_pkg::REG_IMAGE, 10'h035);
        rd(ssf_pkg::REG_CRC, 10'h059);
        rd(ssf_pkg::REG_TRAIN_SYNC, 10'h3a6);
        rd(8'h90, 10'h000);
        rd(ssf_pkg::REG_SYNC_ID, 10'h02a);
        for (int m = 0; m < 2; m++) begin
            {mode_8bit, crc_seed_ones} = {2{m[0]}};
            rnd = lfsr(rnd);
            image_pixel_class = m ? rnd[9:0] : 10'h035;
            @(negedge clock);
            {reg_wr_en, reg_addr, reg_wr_data} = {1'b1, ssf_pkg::REG_IMAGE, image_pixel_class};
            @(negedge clock);
            reg_wr_en = 1'b0;
            rd(ssf_pkg::REG_IMAGE, image_pixel_class);
            trn = {w(10'h3a6), {4{w(10'h3a6)}}};
            repeat (40) @(negedge clock);
            RX.got_q.delete();
            pop_word(g, 1'b0);
            `CHK(g, trn)
            fork
                run_line();
                check_line();
            join
            // Four data items make two kernels; line and frame flags are down again
            rd(ssf_pkg::REG_STATUS, 10'h008);
        end
        tally_and_finish();
    end
endmodule
